// >>> rtl/hv_indirect_data_and_config.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Twelve-bit memory-mapped holding register.
// - Upper nibble echoes command, read-only.
// - Codes 0-3 read config, state, monitor.
// - Codes 8, 9 write config zero, one.
// - Low byte is the data byte.
// - Config zero is 8 bits, resets zero.
// - Bit 7 disables wake thermal shutdown.
// - Bit 6 enables precision oscillator.
// - Bit 5 swaps pull-up for serial mode.
// - Bit 4 drives wake pin high.
// - Bit 3 enables supply monitor interrupt.
// - Bit 2 enables low-voltage flag.
// - Bits 1-0 select LIN driver mode.
// - Command bit 0 reads busy.
// - Serial two-wire link, within 10 us.
// - Bits 2,1 report transmit, read-back success.
module hv_indirect_data_and_config
	import hv_iface_pkg::*;
(
	// System.
	input wire logic clock,
	input wire logic rst_n,
	// Memory-mapped register port.
	input wire logic [31:0] mmr_addr,
	input wire logic mmr_write,
	input wire logic [31:0] mmr_wdata,
	output logic [31:0] mmr_rdata,
	// Status sources on the high-voltage side.
	input wire logic [7:0] hv_state,
	input wire logic [7:0] hv_monitor,
	// Configuration outputs.
	output logic thermal_shutdown_off,
	output logic precision_osc_enable,
	output logic bit_serial_device_mode,
	output logic wake_pin,
	output logic supply_monitor_enable,
	output logic low_voltage_flag_enable,
	output logic [1:0] lin_mode,
	output logic [7:0] hv_config_one,
	// Serial link.
	output logic link_clock,
	output logic link_data_out,
	output logic link_data_oe_n,
	input wire logic link_data_in
);
	logic [11:0] hv_transfer_data, next_hv_transfer_data;
	logic [7:0] hv_config_zero, next_hv_config_zero;
	logic [7:0] next_hv_config_one;
	logic [7:0] active_cmd, next_active_cmd;
	logic busy, next_busy, tx_ok, next_tx_ok, rx_ok, next_rx_ok;
	logic start, done;
	logic [15:0] frame_in;
	logic [7:0] back_byte;
	logic cmd_write, data_write, is_read, is_write, known;

	function automatic logic code_is_read(input logic [7:0] c);
		return c inside {CMD_READ_CFG0, CMD_READ_CFG1, CMD_READ_STATE, CMD_READ_MONITOR};
	endfunction

	function automatic logic code_is_write(input logic [7:0] c);
		return c == CMD_WRITE_CFG0 || c == CMD_WRITE_CFG1;
	endfunction

	assign cmd_write = mmr_write && mmr_addr == ADDR_HV_COMMAND;
	assign data_write = mmr_write && mmr_addr == ADDR_HV_TRANSFER_DATA;
	assign is_read = code_is_read(mmr_wdata[7:0]);
	assign is_write = code_is_write(mmr_wdata[7:0]);
	assign known = is_read || is_write;
	// Commands while busy are dropped.
	assign start = cmd_write && known && !busy;

	// The far end loops the frame back; reads pick the addressed source.
	always_comb begin
		unique case (active_cmd)
			CMD_READ_CFG0: back_byte = hv_config_zero;
			CMD_READ_CFG1: back_byte = hv_config_one;
			CMD_READ_STATE: back_byte = hv_state;
			CMD_READ_MONITOR: back_byte = hv_monitor;
			default: back_byte = frame_in[7:0];
		endcase
	end

	always_comb begin
		next_hv_transfer_data = hv_transfer_data;
		next_hv_config_zero = hv_config_zero;
		next_hv_config_one = hv_config_one;
		next_active_cmd = active_cmd;
		next_busy = busy;
		next_tx_ok = tx_ok;
		next_rx_ok = rx_ok;
		if (data_write && !busy) begin
			next_hv_transfer_data[7:0] = mmr_wdata[7:0];
		end
		if (start) begin
			next_active_cmd = mmr_wdata[7:0];
			next_busy = 1'b1;
		end
		if (done) begin
			next_busy = 1'b0;
			next_tx_ok = 1'b1;
			next_rx_ok = code_is_read(active_cmd) && frame_in[15:8] == active_cmd;
			if (code_is_read(active_cmd)) begin
				next_hv_transfer_data = {active_cmd[3:0], back_byte};
			end else begin
				next_hv_transfer_data[11:8] = active_cmd[3:0];
				if (active_cmd == CMD_WRITE_CFG0) begin
					next_hv_config_zero = hv_transfer_data[7:0];
				end else begin
					next_hv_config_one = hv_transfer_data[7:0];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hv_transfer_data <= TRANSFER_DATA_RESET;
			hv_config_zero <= CFG_ZERO_RESET;
			hv_config_one <= CFG_ONE_RESET;
			active_cmd <= 8'h00;
			busy <= 1'b0;
			tx_ok <= 1'b0;
			rx_ok <= 1'b0;
		end else begin
			hv_transfer_data <= next_hv_transfer_data;
			hv_config_zero <= next_hv_config_zero;
			hv_config_one <= next_hv_config_one;
			active_cmd <= next_active_cmd;
			busy <= next_busy;
			tx_ok <= next_tx_ok;
			rx_ok <= next_rx_ok;
		end
	end

	always_comb begin
		mmr_rdata = 32'h00000000;
		if (mmr_addr == ADDR_HV_TRANSFER_DATA) begin
			mmr_rdata[11:0] = hv_transfer_data;
		end else if (mmr_addr == ADDR_HV_COMMAND) begin
			mmr_rdata[CMD_TX_OK_BIT] = tx_ok && !busy;
			mmr_rdata[CMD_RX_OK_BIT] = rx_ok && !busy;
			mmr_rdata[CMD_BUSY_BIT] = busy;
		end
	end

	assign thermal_shutdown_off = hv_config_zero[CFG0_THERMAL_OFF_BIT];
	assign precision_osc_enable = hv_config_zero[CFG0_OSC_EN_BIT];
	assign bit_serial_device_mode = hv_config_zero[CFG0_BSD_BIT];
	assign wake_pin = hv_config_zero[CFG0_WAKE_BIT];
	assign supply_monitor_enable = hv_config_zero[CFG0_SUPPLY_MON_BIT];
	assign low_voltage_flag_enable = hv_config_zero[CFG0_LOW_FLAG_BIT];
	assign lin_mode = hv_config_zero[CFG0_LIN_MODE_LSB +: 2];

	hv_link_shifter hv_link_shifter_i (
		.clock(clock),
		.rst_n(rst_n),
		.start(start),
		.frame_out({mmr_wdata[7:0], hv_transfer_data[7:0]}),
		.done(done),
		.frame_in(frame_in),
		.link_clock(link_clock),
		.link_data_out(link_data_out),
		.link_data_oe_n(link_data_oe_n),
		.link_data_in(link_data_in)
	);

	logic [10:0] busy_age;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_age <= 11'h000;
		end else begin
			busy_age <= busy ? busy_age + 11'h001 : 11'h000;
		end
	end

	property p_latency;
		@(posedge clock) disable iff (!rst_n) busy |-> busy_age < 11'(LATENCY_MAX_CYCLES);
	endproperty
	a_latency: assert property (p_latency) else $error("command exceeded latency");

	property p_busy_start;
		@(posedge clock) disable iff (!rst_n) start |=> busy;
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy not set");

	property p_write0;
		@(posedge clock) disable iff (!rst_n)
			done && active_cmd == CMD_WRITE_CFG0 |=> hv_config_zero == $past(hv_transfer_data[7:0]);
	endproperty
	a_write0: assert property (p_write0) else $error("config zero not written");

	property p_readback;
		@(posedge clock) disable iff (!rst_n)
			done && code_is_read(active_cmd) |=> hv_transfer_data == {$past(active_cmd[3:0]), $past(back_byte)};
	endproperty
	a_readback: assert property (p_readback) else $error("read-back not loaded");

	property p_cfg_stable;
		@(posedge clock) disable iff (!rst_n) !done |=> $stable(hv_config_zero);
	endproperty
	a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without command");

	property p_upper_ro;
		@(posedge clock) disable iff (!rst_n) !done |=> $stable(hv_transfer_data[11:8]);
	endproperty
	a_upper_ro: assert property (p_upper_ro) else $error("command echo changed by software");

	property p_status_hidden;
		@(posedge clock) disable iff (!rst_n)
			busy && mmr_addr == ADDR_HV_COMMAND |-> mmr_rdata[2:0] == 3'h1;
	endproperty
	a_status_hidden: assert property (p_status_hidden) else $error("status shown while busy");

	// A completed write to config zero must reach every output decoded from config zero in the next cycle.
	property p_lin;
		@(posedge clock) disable iff (!rst_n)
			done && active_cmd == CMD_WRITE_CFG0 |=>
			{thermal_shutdown_off, precision_osc_enable, bit_serial_device_mode, wake_pin,
			supply_monitor_enable, low_voltage_flag_enable, lin_mode} == $past(hv_transfer_data[7:0]);
	endproperty
	a_lin: assert property (p_lin) else $error("config output mismatch");
endmodule

// >>> rtl/hv_iface_pkg.sv
package hv_iface_pkg;
	// Memory-mapped register byte addresses.
	localparam logic [31:0] ADDR_HV_COMMAND = 32'hFFFF0804;
	localparam logic [31:0] ADDR_HV_TRANSFER_DATA = 32'hFFFF080C;
	// Command codes.
	localparam logic [7:0] CMD_READ_CFG0 = 8'h00;
	localparam logic [7:0] CMD_READ_CFG1 = 8'h01;
	localparam logic [7:0] CMD_READ_STATE = 8'h02;
	localparam logic [7:0] CMD_READ_MONITOR = 8'h03;
	localparam logic [7:0] CMD_WRITE_CFG0 = 8'h08;
	localparam logic [7:0] CMD_WRITE_CFG1 = 8'h09;
	// Reset values.
	localparam logic [7:0] CFG_ZERO_RESET = 8'h00;
	localparam logic [7:0] CFG_ONE_RESET = 8'h00;
	localparam logic [11:0] TRANSFER_DATA_RESET = 12'h000;
	// Configuration register 0 fields.
	localparam int CFG0_THERMAL_OFF_BIT = 7;
	localparam int CFG0_OSC_EN_BIT = 6;
	localparam int CFG0_BSD_BIT = 5;
	localparam int CFG0_WAKE_BIT = 4;
	localparam int CFG0_SUPPLY_MON_BIT = 3;
	localparam int CFG0_LOW_FLAG_BIT = 2;
	localparam int CFG0_LIN_MODE_LSB = 0;
	// Command register read-back fields.
	localparam int CMD_TX_OK_BIT = 2;
	localparam int CMD_RX_OK_BIT = 1;
	localparam int CMD_BUSY_BIT = 0;
	// Serial link timing.
	localparam int CLOCK_HZ = 100000000;
	localparam int LINK_HZ = 2560000;
	localparam int LINK_HALF_CYCLES = CLOCK_HZ / (2 * LINK_HZ);
	localparam int LATENCY_MAX_NS = 10000;
	localparam int LATENCY_MAX_CYCLES = LATENCY_MAX_NS / 10;
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] FRAME_BITS_W = 5'h10;
	// Start-up allowance for the precision oscillator, software side.
	localparam int OSC_STARTUP_US = 70;
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_SHIFT = 2'b01,
		LINK_DONE = 2'b11
	} link_state_type;
endpackage

// >>> rtl/hv_link_shifter.sv
`timescale 1ns/1ns
module hv_link_shifter
	import hv_iface_pkg::*;
(
	// System.
	input wire logic clock,
	input wire logic rst_n,
	// Request side.
	input wire logic start,
	input wire logic [15:0] frame_out,
	output logic done,
	output logic [15:0] frame_in,
	// Serial pins.
	output logic link_clock,
	output logic link_data_out,
	output logic link_data_oe_n,
	input wire logic link_data_in
);
	link_state_type state, next_state;
	logic [5:0] div, next_div;
	logic [4:0] count, next_count;
	logic [15:0] shift_out, next_shift_out;
	logic [15:0] shift_in, next_shift_in;
	logic next_link_clock;
	logic tick;

	assign tick = (div == 6'(LINK_HALF_CYCLES - 1));

	always_comb begin
		next_state = state;
		next_div = (state == LINK_SHIFT && !tick) ? div + 6'h01 : 6'h00;
		next_count = count;
		next_shift_out = shift_out;
		next_shift_in = shift_in;
		next_link_clock = link_clock;
		unique case (state)
			LINK_IDLE: begin
				next_link_clock = 1'b0;
				if (start) begin
					next_state = LINK_SHIFT;
					next_shift_out = frame_out;
					next_count = 5'h00;
				end
			end
			LINK_SHIFT: begin
				if (tick) begin
					next_link_clock = !link_clock;
					if (!link_clock) begin
						next_shift_in = {shift_in[14:0], link_data_in};
					end else begin
						next_shift_out = {shift_out[14:0], 1'b0};
						next_count = count + 5'h01;
						if (count == FRAME_BITS_W - 5'h01) begin
							next_state = LINK_DONE;
						end
					end
				end
			end
			LINK_DONE: begin
				next_state = LINK_IDLE;
			end
			// The unused code returns the link to idle.
			default: begin
				next_state = LINK_IDLE;
				next_link_clock = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= LINK_IDLE;
			div <= 6'h00;
			count <= 5'h00;
			shift_out <= 16'h0000;
			shift_in <= 16'h0000;
			link_clock <= 1'b0;
		end else begin
			state <= next_state;
			div <= next_div;
			count <= next_count;
			shift_out <= next_shift_out;
			shift_in <= next_shift_in;
			link_clock <= next_link_clock;
		end
	end

	assign done = (state == LINK_DONE);
	assign frame_in = shift_in;
	assign link_data_out = shift_out[15];
	// Data is driven only while a frame is shifted.
	assign link_data_oe_n = (state != LINK_SHIFT);
endmodule

// >>> testbench/hv_far_side.sv
`timescale 1ns/1ns
module hv_far_side (
	// Link pins.
	input wire logic link_clock,
	input wire logic link_data_out,
	input wire logic link_data_oe_n,
	output logic link_data_in,
	// Fault injection and observation.
	input wire logic corrupt,
	output logic [15:0] frame_seen
);
	logic last = 1'b0;
	logic wire_level;
	initial frame_seen = 16'h0000;
	always @(posedge link_clock) begin
		frame_seen <= {frame_seen[14:0], wire_level};
	end
	always @* begin
		if (!link_data_oe_n) begin
			last = link_data_out;
		end
	end
	// A released line with no pull shows the inverse of its last value.
	assign wire_level = !link_data_oe_n ? link_data_out : ~last;
	assign link_data_in = corrupt ? ~wire_level : wire_level;
endmodule

// >>> testbench/tb_hv_indirect_data_and_config.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t %0h %0h", $time, (a), (b)); end end
module tb_hv_indirect_data_and_config;
	import hv_iface_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] mmr_addr = 32'h00000000;
	logic mmr_write = 1'b0;
	logic [31:0] mmr_wdata = 32'h00000000;
	logic [31:0] mmr_rdata;
	logic [7:0] hv_state = 8'h96;
	logic [7:0] hv_monitor = 8'h69;
	logic ts, po, bs, wk, sm, lv;
	logic [1:0] lin_mode;
	logic [7:0] cfg1;
	logic link_clock, link_data_out, link_data_oe_n, link_data_in;
	logic corrupt = 1'b0;
	logic [15:0] frame_seen;
	logic [31:0] r;
	int fails = 0;
	int checked = 0;
	always #5 clock = ~clock;
	hv_indirect_data_and_config hv_indirect_data_and_config_i (.clock(clock), .rst_n(rst_n),
		.mmr_addr(mmr_addr), .mmr_write(mmr_write), .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata),
		.hv_state(hv_state), .hv_monitor(hv_monitor), .thermal_shutdown_off(ts), .precision_osc_enable(po),
		.bit_serial_device_mode(bs), .wake_pin(wk), .supply_monitor_enable(sm), .low_voltage_flag_enable(lv),
		.lin_mode(lin_mode), .hv_config_one(cfg1), .link_clock(link_clock), .link_data_out(link_data_out),
		.link_data_oe_n(link_data_oe_n), .link_data_in(link_data_in));
	hv_far_side hv_far_side_i (.link_clock(link_clock), .link_data_out(link_data_out),
		.link_data_oe_n(link_data_oe_n), .link_data_in(link_data_in), .corrupt(corrupt),
		.frame_seen(frame_seen));
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		#1 mmr_addr = a;
		mmr_wdata = d;
		mmr_write = 1'b1;
		@(posedge clock);
		#1 mmr_write = 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge clock);
		#1 mmr_addr = a;
		#2 r = mmr_rdata;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		rd(ADDR_HV_COMMAND);
		`CHK(r[0], 1'b1)
		while (r[0] === 1'b1 && n < 2000) begin
			rd(ADDR_HV_COMMAND);
			n++;
		end
		`CHK(n < LATENCY_MAX_CYCLES, 1'b1)
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(ADDR_HV_COMMAND, {24'h000000, c});
		wait_idle();
	endtask
	task automatic t_reset;
		rd(ADDR_HV_TRANSFER_DATA);
		`CHK(r, {20'h00000, TRANSFER_DATA_RESET})
		`CHK({ts, po, bs, wk, sm, lv, lin_mode}, CFG_ZERO_RESET)
		`CHK({link_clock, link_data_oe_n}, 2'b01)
		rd(32'hFFFF0808);
		`CHK(r, 32'h00000000)
	endtask
	task automatic t_write_cfg0(input logic [7:0] v);
		wr(ADDR_HV_TRANSFER_DATA, {24'h000000, v});
		cmd(CMD_WRITE_CFG0);
		`CHK({r[2], r[0]}, 2'b10)
		`CHK(frame_seen, {CMD_WRITE_CFG0, v})
		`CHK(ts, v[7])
		`CHK(po, v[6])
		`CHK(bs, v[5])
		`CHK(wk, v[4])
		`CHK(sm, v[3])
		`CHK(lv, v[2])
		`CHK(lin_mode, v[1:0])
		rd(ADDR_HV_TRANSFER_DATA);
		`CHK(r, {20'h00000, 4'h8, v})
	endtask
	task automatic t_write_cfg1(input logic [7:0] v);
		wr(ADDR_HV_TRANSFER_DATA, {24'h000000, v});
		cmd(CMD_WRITE_CFG1);
		`CHK(cfg1, v)
		rd(ADDR_HV_TRANSFER_DATA);
		`CHK(r, {20'h00000, 4'h9, v})
	endtask
	task automatic t_read(input logic [7:0] c, input logic [7:0] v);
		cmd(c);
		`CHK(r[2:0], 3'h6)
		rd(ADDR_HV_TRANSFER_DATA);
		`CHK(r, {20'h00000, c[3:0], v})
	endtask
	task automatic t_busy_refuse;
		wr(ADDR_HV_TRANSFER_DATA, 32'h000000A5);
		wr(ADDR_HV_COMMAND, {24'h000000, CMD_WRITE_CFG0});
		wr(ADDR_HV_TRANSFER_DATA, 32'h000000EE);
		wr(ADDR_HV_COMMAND, {24'h000000, CMD_WRITE_CFG1});
		wait_idle();
		`CHK({ts, po, bs, wk, sm, lv, lin_mode}, 8'hA5)
		`CHK(cfg1, 8'h3C)
		rd(ADDR_HV_TRANSFER_DATA);
		`CHK(r, 32'h000008A5)
	endtask
	task automatic t_unknown;
		wr(ADDR_HV_COMMAND, 32'h00000004);
		rd(ADDR_HV_COMMAND);
		`CHK(r[0], 1'b0)
		rd(ADDR_HV_TRANSFER_DATA);
		`CHK(r, 32'h000008A5)
	endtask
	task automatic t_corrupt;
		@(posedge clock);
		#1 corrupt = 1'b1;
		cmd(CMD_READ_STATE);
		`CHK(r[1], 1'b0)
		rd(ADDR_HV_TRANSFER_DATA);
		`CHK(r, {20'h00000, 4'h2, hv_state})
		@(posedge clock);
		#1 corrupt = 1'b0;
	endtask
	task automatic results;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clock);
		#1 rst_n = 1'b1;
		t_reset();
		t_write_cfg0(8'h00);
		t_write_cfg0(8'hA5);
		t_write_cfg0(8'hC3);
		t_write_cfg0(8'h5A);
		t_write_cfg1(8'h3C);
		t_read(CMD_READ_CFG0, 8'h5A);
		t_read(CMD_READ_CFG1, 8'h3C);
		t_read(CMD_READ_STATE, hv_state);
		t_read(CMD_READ_MONITOR, hv_monitor);
		t_busy_refuse();
		t_unknown();
		t_corrupt();
		results();
	end
	initial begin
		#600000;
		fails++;
		results();
	end
endmodule
